/* File: hw/fault_summary_status_regs.sv */
// fault summary byte and word plus the output voltage fault flag register
`timescale 1ns/1ps
import fault_summary_pkg::*;

// Notes on behaviour
// - byte read of 78h returns the one-byte fault summary
// - summary byte and low byte of the summary word are one register
// - summary bits other than live bits 6 and 11, busy bit 7 and the unclassified cause in bit 0 only mirror detail flags; clearing a detail clears the summary
// - bit 7 set when a fault was declared because the device was busy
// - bit 6 live: one whenever conversion is not running
// - bits 5,4,3 show overvoltage, overcurrent and input undervoltage faults
// - bit 2 set by any temperature fault or warning
// - bit 1 set by a communication, memory or logic fault
// - bit 0 set by any fault not covered by other byte bits
// - byte write of 80h clears the busy bit
// - word read of 79h returns the summary word, low byte the summary byte
// - bits 15 and 14 show output voltage and output current faults
// - bits 13 and 12 show input and vendor faults
// - bit 11 live, one when output is outside the regulation window
// - bit 9 set by a miscellaneous fault
// - bits 10 and 8 always read zero
// - word write 0080h clears busy; 0180h clears busy and unclassified condition
// - each alert-capable bit has a matching alert enable mask bit
// - 7Ah byte register; flags clear by global clear or writing one
// - 7Ah bits 7..2 are latched voltage flags, bits 1..0 read zero
module fault_summary_status_regs (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        SRST,
    // command access from the bus engine
    input  wire logic [7:0]  CMD_CODE,
    input  wire logic        WR_STB,
    input  wire logic        WR_WORD,
    input  wire logic [15:0] WR_DATA,
    input  wire logic        RD_STB,
    output logic [15:0]      RD_DATA,
    output logic             RD_VALID,
    output logic             CMD_HIT,
    // global clear of all latched faults
    input  wire logic        CLEAR_FAULTS,
    // fault events, one-cycle pulses
    input  wire logic        BUSY_EVENT,
    input  wire logic        UNCLASSIFIED_EVENT,
    input  wire logic [5:0]  OUTPUT_VOLTAGE_SUMMARY_EVENT,
    // summaries of detail registers kept elsewhere
    input  wire logic        OUTPUT_CURRENT_SUMMARY,
    input  wire logic        OVERCURRENT_SUMMARY,
    input  wire logic        INPUT_FAULT_SUMMARY,
    input  wire logic        INPUT_UNDERVOLT_SUMMARY,
    input  wire logic        TEMP_SUMMARY,
    input  wire logic        COMM_LOGIC_SUMMARY,
    input  wire logic        VENDOR_FAULT_SUMMARY,
    input  wire logic        OTHER_SUMMARY,
    // live conditions
    input  wire logic        CONVERTING,
    input  wire logic        POWER_OK_LIVE,
    // alert path
    input  wire logic [15:0] ALERT_ENABLE_MASK,
    input  wire logic [7:0]  OUTPUT_VOLTAGE_SUMMARY_ALERT_MASK,
    output logic             ALERT_REQ,
    // flag views
    output logic [7:0]       SUMMARY_BYTE,
    output logic [15:0]      SUMMARY_WORD,
    output logic [7:0]       OUTPUT_VOLTAGE_SUMMARY_FLAGS
);
    import fault_summary_pkg::*;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic hit_byte;
    logic hit_word;
    logic hit_output_voltage_summary;
    logic busy_flag;
    logic unclassified_flag;
    logic busy_clr;
    logic unclassified_clr;
    logic [OUTPUT_VOLTAGE_SUMMARY_FLAG_CNT-1:0] output_voltage_summary_flag;
    logic [OUTPUT_VOLTAGE_SUMMARY_FLAG_CNT-1:0] output_voltage_summary_clr;
    logic [7:0]  byte_d;
    logic [15:0] word_d;
    logic [7:0]  output_voltage_summary_d;
    logic [15:0] rd_d;
    logic [15:0] rd_q;
    logic        rd_valid_q;
    logic [7:0]  byte_q;
    logic [7:0]  word_hi_q;
    logic [7:0]  output_voltage_summary_q;
    logic        alert_q;
    logic        byte_wr;
    logic        word_wr;
    logic        byte_busy_wr;
    logic        word_busy_wr;
    logic        word_both_wr;
    logic [15:0] word_alert_src;
    logic [7:0]  output_voltage_summary_alert_src;
    logic [OUTPUT_VOLTAGE_SUMMARY_FLAG_CNT-1:0] output_voltage_summary_wr_ones;

    // decode stays combinational so the hit answers in the cycle of the request
    assign hit_byte = (CMD_CODE == CMD_SUMMARY_BYTE);
    assign hit_word = (CMD_CODE == CMD_SUMMARY_WORD);
    assign hit_output_voltage_summary = (CMD_CODE == CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS);
    assign CMD_HIT  = hit_byte | hit_word | hit_output_voltage_summary;

    // ------------------------------------------------------------------
    // busy and unclassified flags
    // ------------------------------------------------------------------
    // byte write 80h clears busy
    // word write 0080h clears busy, 0180h clears busy and unclassified
    // other values leave flags unchanged
    // a byte write only counts on a byte code and a word write only on the word code
    assign byte_wr          = WR_STB & ~WR_WORD;
    assign word_wr          = WR_STB & WR_WORD;
    assign byte_busy_wr     = byte_wr & hit_byte & (WR_DATA[7:0] == BYTE_BUSY_CLEAR);
    assign word_busy_wr     = word_wr & hit_word & (WR_DATA == WORD_BUSY_CLEAR);
    assign word_both_wr     = word_wr & hit_word & (WR_DATA == WORD_BOTH_CLEAR);
    assign busy_clr         = CLEAR_FAULTS | byte_busy_wr | word_busy_wr | word_both_wr;
    assign unclassified_clr = CLEAR_FAULTS | word_both_wr;

    // busy declared fault latch
    // set wins over a clear in the same cycle, so a late event is never lost
    sticky_flag u_busy (
        .MCLK (MCLK),
        .SRST (SRST),
        .SET  (BUSY_EVENT),
        .CLR  (busy_clr),
        .FLAG (busy_flag)
    );

    sticky_flag u_unclassified (
        .MCLK (MCLK),
        .SRST (SRST),
        .SET  (UNCLASSIFIED_EVENT),
        .CLR  (unclassified_clr),
        .FLAG (unclassified_flag)
    );

    // ------------------------------------------------------------------
    // output voltage flags
    // ------------------------------------------------------------------
    // write-one-to-clear or global clear, set wins
    // bits 7..2 latched, per bit
    // writing zero to a flag position leaves that flag alone
    assign output_voltage_summary_wr_ones = (byte_wr & hit_output_voltage_summary) ? WR_DATA[BIT_OUTPUT_OVERVOLT_FAULT_FLAG:BIT_STARTUP_TIMEOUT_FLAG] : '0;

    generate
        for (genvar i = 0; i < OUTPUT_VOLTAGE_SUMMARY_FLAG_CNT; i++) begin : g_output_voltage_summary
            assign output_voltage_summary_clr[i] = CLEAR_FAULTS | output_voltage_summary_wr_ones[i];
            sticky_flag u_flag (
                .MCLK (MCLK),
                .SRST (SRST),
                .SET  (OUTPUT_VOLTAGE_SUMMARY_EVENT[i]),
                .CLR  (output_voltage_summary_clr[i]),
                .FLAG (output_voltage_summary_flag[i])
            );
        end
    endgenerate

    assign output_voltage_summary_d = {output_voltage_summary_flag, 2'b00};

    // ------------------------------------------------------------------
    // summary composition
    // ------------------------------------------------------------------
    // summary follows detail flags and the live inputs only, nothing stored here
    always_comb begin
        byte_d = RST_BYTE;
        byte_d[BIT_BUSY]     = busy_flag;
        byte_d[BIT_OFF]      = ~CONVERTING;
        byte_d[BIT_OV]       = output_voltage_summary_flag[BIT_OUTPUT_OVERVOLT_FAULT_FLAG - BIT_STARTUP_TIMEOUT_FLAG];
        byte_d[BIT_OC]       = OVERCURRENT_SUMMARY;
        byte_d[BIT_INPUT_UNDERVOLT_SUMMARY]   = INPUT_UNDERVOLT_SUMMARY;
        byte_d[BIT_TEMP]     = TEMP_SUMMARY;
        byte_d[BIT_CML]      = COMM_LOGIC_SUMMARY;
        // unlisted fault pointer
        // collects every latched cause that has no bit of its own in this byte
        byte_d[BIT_UNLISTED] = unclassified_flag | VENDOR_FAULT_SUMMARY | OTHER_SUMMARY
                               | (|output_voltage_summary_flag[BIT_OUTPUT_VOLTAGE_SUMMARY_LIM - BIT_STARTUP_TIMEOUT_FLAG +: 4])
                               | output_voltage_summary_flag[0]
                               | (OUTPUT_CURRENT_SUMMARY & ~OVERCURRENT_SUMMARY)
                               | (INPUT_FAULT_SUMMARY & ~INPUT_UNDERVOLT_SUMMARY);
    end

    always_comb begin
        word_d = 16'h0000;
        // low byte is the summary byte itself
        word_d[7:0]          = byte_d;
        word_d[BIT_OUTPUT_VOLTAGE_SUMMARY]     = |output_voltage_summary_flag;
        word_d[BIT_OUTPUT_CURRENT_SUMMARY]     = OUTPUT_CURRENT_SUMMARY;
        word_d[BIT_INPUT]    = INPUT_FAULT_SUMMARY;
        word_d[BIT_VENDOR]   = VENDOR_FAULT_SUMMARY;
        word_d[BIT_PWR_BAD]  = ~POWER_OK_LIVE;
        word_d[BIT_OTHER]    = OTHER_SUMMARY;
    end

    // ------------------------------------------------------------------
    // registered views
    // ------------------------------------------------------------------
    // one set of flops serves the byte and the low byte of the word
    // views lag the state by one cycle; the read path uses the next-state terms
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            byte_q <= RST_BYTE;
        end else begin
            byte_q <= byte_d;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            word_hi_q <= 8'h00;
        end else begin
            word_hi_q <= word_d[15:8];
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            output_voltage_summary_q <= 8'h00;
        end else begin
            output_voltage_summary_q <= output_voltage_summary_d;
        end
    end

    assign SUMMARY_BYTE = byte_q;
    assign SUMMARY_WORD = {word_hi_q, byte_q};
    assign OUTPUT_VOLTAGE_SUMMARY_FLAGS   = output_voltage_summary_q;

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // byte read, word read
    always_comb begin
        rd_d = 16'h0000;
        case (CMD_CODE)
            CMD_SUMMARY_BYTE: begin
                rd_d = {8'h00, byte_d};
            end
            CMD_SUMMARY_WORD: begin
                rd_d = word_d;
            end
            CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS: begin
                rd_d = {8'h00, output_voltage_summary_d};
            end
            default: begin
                rd_d = 16'h0000;
            end
        endcase
    end

    // refused codes still load zero so stale data never looks like an answer
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rd_q <= 16'h0000;
        end else if (RD_STB) begin
            rd_q <= rd_d;
        end
    end

    // the answer pulse only follows a strobe on a mapped code
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= RD_STB & CMD_HIT;
        end
    end

    assign RD_DATA  = rd_q;
    assign RD_VALID = rd_valid_q;

    // ------------------------------------------------------------------
    // alert request
    // ------------------------------------------------------------------
    // each alert-capable bit gated by its enable
    // live bits report a state, not an event, so they are kept out of the alert
    always_comb begin
        word_alert_src              = word_d & ALERT_ENABLE_MASK;
        word_alert_src[BIT_OFF]     = 1'b0;
        word_alert_src[BIT_PWR_BAD] = 1'b0;
        output_voltage_summary_alert_src              = output_voltage_summary_d & OUTPUT_VOLTAGE_SUMMARY_ALERT_MASK & OUTPUT_VOLTAGE_SUMMARY_FLAG_MASK;
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            alert_q <= 1'b0;
        end else begin
            alert_q <= (|word_alert_src) | (|output_voltage_summary_alert_src);
        end
    end

    assign ALERT_REQ = alert_q;
endmodule

/* File: hw/fault_summary_pkg.sv */
// package: command codes, bit positions and write values of the fault summary registers
package fault_summary_pkg;
    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
    localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS   = 8'h7A;

    // ------------------------------------------------------------------
    // summary byte bit positions
    // ------------------------------------------------------------------
    localparam int BIT_BUSY       = 7;
    localparam int BIT_OFF        = 6;
    localparam int BIT_OV         = 5;
    localparam int BIT_OC         = 4;
    localparam int BIT_INPUT_UNDERVOLT_SUMMARY     = 3;
    localparam int BIT_TEMP       = 2;
    localparam int BIT_CML        = 1;
    localparam int BIT_UNLISTED   = 0;

    // ------------------------------------------------------------------
    // summary word high byte positions
    // ------------------------------------------------------------------
    localparam int BIT_OUTPUT_VOLTAGE_SUMMARY       = 15;
    localparam int BIT_OUTPUT_CURRENT_SUMMARY       = 14;
    localparam int BIT_INPUT      = 13;
    localparam int BIT_VENDOR     = 12;
    localparam int BIT_PWR_BAD    = 11;
    localparam int BIT_OTHER      = 9;

    // ------------------------------------------------------------------
    // output voltage flag positions and masks
    // ------------------------------------------------------------------
    localparam int BIT_OUTPUT_OVERVOLT_FAULT_FLAG   = 7;
    localparam int BIT_OUTPUT_OVERVOLT_WARN_FLAG   = 6;
    localparam int BIT_OUTPUT_UNDERVOLT_WARN_FLAG   = 5;
    localparam int BIT_OUTPUT_UNDERVOLT_FAULT_FLAG   = 4;
    localparam int BIT_OUTPUT_VOLTAGE_SUMMARY_LIM   = 3;
    localparam int BIT_STARTUP_TIMEOUT_FLAG    = 2;
    localparam int OUTPUT_VOLTAGE_SUMMARY_FLAG_CNT  = 6;
    localparam logic [7:0] OUTPUT_VOLTAGE_SUMMARY_FLAG_MASK = 8'hFC;

    // ------------------------------------------------------------------
    // clearing write values and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  BYTE_BUSY_CLEAR = 8'h80;
    localparam logic [15:0] WORD_BUSY_CLEAR = 16'h0080;
    localparam logic [15:0] WORD_BOTH_CLEAR = 16'h0180;
    localparam logic [7:0]  RST_BYTE        = 8'h00;
endpackage

/* File: hw/sticky_flag.sv */
// single latched flag: hardware set wins over software or global clear
`timescale 1ns/1ps
module sticky_flag (
    // clock and reset
    input  wire logic MCLK,
    input  wire logic SRST,
    // set and clear
    input  wire logic SET,
    input  wire logic CLR,
    // state
    output logic      FLAG
);
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            FLAG <= 1'b0;
        end else if (SET) begin
            FLAG <= 1'b1;
        end else if (CLR) begin
            FLAG <= 1'b0;
        end
    end
endmodule

/* File: sim/fault_summary_status_regs_assertions.sv */
// checker for the fault summary register ports
`timescale 1ns/1ps
module fault_summary_checker
    import fault_summary_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        SRST,
    input wire logic [7:0]  CMD_CODE,
    input wire logic        WR_STB,
    input wire logic        WR_WORD,
    input wire logic [15:0] WR_DATA,
    input wire logic        RD_STB,
    input wire logic [15:0] RD_DATA,
    input wire logic        RD_VALID,
    input wire logic        CMD_HIT,
    input wire logic        CONVERTING,
    input wire logic        BUSY_EVENT,
    input wire logic [5:0]  OUTPUT_VOLTAGE_SUMMARY_EVENT,
    input wire logic [7:0]  SUMMARY_BYTE,
    input wire logic [15:0] SUMMARY_WORD,
    input wire logic [7:0]  OUTPUT_VOLTAGE_SUMMARY_FLAGS
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    rd_answer_a: assert property (RD_STB && CMD_HIT |=> RD_VALID)
        else $error("read not answered");
    rd_cause_a: assert property (RD_VALID |-> $past(RD_STB) && $past(CMD_HIT))
        else $error("answer without request");
    refuse_zero_a: assert property (RD_STB && !CMD_HIT |=> !RD_VALID && RD_DATA == 16'h0000)
        else $error("unmapped read answered");
    one_register_a: assert property (SUMMARY_WORD[7:0] == SUMMARY_BYTE)
        else $error("byte and word low differ");
    zero_bits_a: assert property (
        SUMMARY_WORD[10] == 1'b0 && SUMMARY_WORD[8] == 1'b0 && OUTPUT_VOLTAGE_SUMMARY_FLAGS[1:0] == 2'h0)
        else $error("unsupported bit set");
    off_live_a: assert property (CONVERTING[*3] |-> !SUMMARY_BYTE[BIT_OFF])
        else $error("off bit set while converting");
    ov_views_a: assert property (
        OUTPUT_VOLTAGE_SUMMARY_EVENT[5] |-> ##2 OUTPUT_VOLTAGE_SUMMARY_FLAGS[BIT_OUTPUT_OVERVOLT_FAULT_FLAG] && SUMMARY_BYTE[BIT_OV]
            && SUMMARY_WORD[BIT_OUTPUT_VOLTAGE_SUMMARY])
        else $error("overvoltage not shown");
    busy_clear_a: assert property (
        (WR_STB && !WR_WORD && CMD_CODE == CMD_SUMMARY_BYTE
            && WR_DATA[7:0] == BYTE_BUSY_CLEAR && !BUSY_EVENT) ##1 !BUSY_EVENT
        |=> !SUMMARY_BYTE[BIT_BUSY])
        else $error("busy not cleared");
endmodule

bind fault_summary_status_regs fault_summary_checker i_fault_summary_checker (
    .MCLK, .SRST, .CMD_CODE, .WR_STB, .WR_WORD, .WR_DATA, .RD_STB, .RD_DATA, .RD_VALID,
    .CMD_HIT, .CONVERTING, .BUSY_EVENT, .OUTPUT_VOLTAGE_SUMMARY_EVENT, .SUMMARY_BYTE, .SUMMARY_WORD, .OUTPUT_VOLTAGE_SUMMARY_FLAGS
);

/* File: sim/status_host_model.sv */
// host side model issuing one-cycle command reads and writes
`timescale 1ns/1ps
module status_host_model (
    input  wire logic        mclk,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    output logic [7:0]       cmd_code,
    output logic             wr_stb,
    output logic             wr_word,
    output logic [15:0]      wr_data,
    output logic             rd_stb
);
    initial begin
        cmd_code = 8'h00;
        wr_stb = 1'b0;
        wr_word = 1'b0;
        wr_data = 16'h0000;
        rd_stb = 1'b0;
    end
    // data is inverted once the strobe drops so a stale value is never mistaken for new
    task automatic write_cmd(input logic [7:0] c, input logic w, input logic [15:0] d);
        @(posedge mclk);
        #1;
        cmd_code = c;
        wr_word = w;
        wr_data = d;
        wr_stb = 1'b1;
        @(posedge mclk);
        #1;
        wr_stb = 1'b0;
        wr_data = ~d;
    endtask
    task automatic read_cmd(input logic [7:0] c, output logic [15:0] d, output logic v);
        @(posedge mclk);
        #1;
        cmd_code = c;
        rd_stb = 1'b1;
        @(posedge mclk);
        #1;
        rd_stb = 1'b0;
        v = rd_valid;
        d = rd_data;
    endtask
endmodule

/* File: sim/fault_summary_status_regs_tb.sv */
// self-checking bench for the fault summary registers
`timescale 1ns/1ps
module fault_summary_status_regs_tb;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        converting = 1'b1;
    logic        power_ok = 1'b1;
    logic [8:0]  ev = 9'h000;
    logic [7:0]  mir = 8'h00;
    logic [15:0] amask = 16'h0000;
    logic [7:0]  vmask = 8'h00;
    logic [7:0]  cmd_code, output_voltage_summary_flags, summary_byte;
    logic [15:0] wr_data, rd_data, summary_word;
    logic        wr_stb, wr_word, rd_stb, rd_valid, cmd_hit, alert_req;
    int          mismatches = 0;
    int          check_count = 0;
    // mirror inputs in upper byte, expected summary word below
    logic [23:0] tab [8] = '{24'h804001, 24'hC04010, 24'h202001, 24'h302008,
                             24'h080004, 24'h040002, 24'h021001, 24'h010201};
    always #5 mclk = ~mclk;
    fault_summary_status_regs i_fault_summary_status_regs (
        .MCLK(mclk), .SRST(srst), .CMD_CODE(cmd_code), .WR_STB(wr_stb), .WR_WORD(wr_word),
        .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .CMD_HIT(cmd_hit), .CLEAR_FAULTS(ev[8]), .BUSY_EVENT(ev[7]),
        .UNCLASSIFIED_EVENT(ev[6]), .OUTPUT_VOLTAGE_SUMMARY_EVENT(ev[5:0]), .OUTPUT_CURRENT_SUMMARY(mir[7]),
        .OVERCURRENT_SUMMARY(mir[6]), .INPUT_FAULT_SUMMARY(mir[5]),
        .INPUT_UNDERVOLT_SUMMARY(mir[4]), .TEMP_SUMMARY(mir[3]), .COMM_LOGIC_SUMMARY(mir[2]),
        .VENDOR_FAULT_SUMMARY(mir[1]), .OTHER_SUMMARY(mir[0]), .CONVERTING(converting),
        .POWER_OK_LIVE(power_ok), .ALERT_ENABLE_MASK(amask), .OUTPUT_VOLTAGE_SUMMARY_ALERT_MASK(vmask),
        .ALERT_REQ(alert_req), .SUMMARY_BYTE(summary_byte), .SUMMARY_WORD(summary_word),
        .OUTPUT_VOLTAGE_SUMMARY_FLAGS(output_voltage_summary_flags)
    );
    status_host_model i_status_host_model (
        .mclk(mclk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_code(cmd_code),
        .wr_stb(wr_stb), .wr_word(wr_word), .wr_data(wr_data), .rd_stb(rd_stb)
    );
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] d;
        logic        v;
        i_status_host_model.read_cmd(c, d, v);
        chk(d, e);
        chk({15'h0000, v}, {15'h0000, c inside {8'h78, 8'h79, 8'h7A}});
        chk({15'h0000, cmd_hit}, {15'h0000, c inside {8'h78, 8'h79, 8'h7A}});
    endtask
    task automatic wr(input logic [7:0] c, input logic w, input logic [15:0] d);
        i_status_host_model.write_cmd(c, w, d);
    endtask
    // live inputs pass through view registers, so give them time to land
    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic pulse(input logic [8:0] v);
        @(posedge mclk);
        #1;
        ev = v;
        @(posedge mclk);
        #1;
        ev = 9'h000;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        srst = 1'b0;
        rdc(8'h78, 16'h0000);
        rdc(8'h79, 16'h0000);
        rdc(8'h7A, 16'h0000);
        rdc(8'h7B, 16'h0000);
        converting = 1'b0;
        power_ok = 1'b0;
        settle;
        rdc(8'h79, 16'h0840);
        converting = 1'b1;
        power_ok = 1'b1;
        foreach (tab[i]) begin
            mir = tab[i][23:16];
            settle;
            chk(summary_word, tab[i][15:0]);
            rdc(8'h79, tab[i][15:0]);
            rdc(8'h78, {8'h00, tab[i][7:0]});
        end
        mir = 8'h00;
        settle;
        rdc(8'h79, 16'h0000);
        pulse(9'h080);
        wr(8'h78, 1'b0, 16'h0000);
        rdc(8'h78, 16'h0080);
        wr(8'h78, 1'b0, 16'h0080);
        rdc(8'h78, 16'h0000);
        pulse(9'h0C0);
        wr(8'h79, 1'b1, 16'h0100);
        wr(8'h79, 1'b1, 16'h0080);
        rdc(8'h79, 16'h0001);
        wr(8'h79, 1'b1, 16'h0180);
        rdc(8'h79, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            pulse(9'h001 << i);
            wr(8'h7A, 1'b0, 16'h0000);
            rdc(8'h7A, 16'h0004 << i);
            rdc(8'h79, (i == 5) ? 16'h8020 : 16'h8001);
            wr(8'h7A, 1'b0, 16'h0004 << i);
            rdc(8'h7A, 16'h0000);
            rdc(8'h79, 16'h0000);
        end
        pulse(9'h0BF);
        rdc(8'h7A, 16'h00FC);
        chk({8'h00, output_voltage_summary_flags}, 16'h00FC);
        chk({15'h0000, alert_req}, 16'h0000);
        vmask = 8'h80;
        settle;
        chk({15'h0000, alert_req}, 16'h0001);
        vmask = 8'h00;
        pulse(9'h100);
        rdc(8'h79, 16'h0000);
        pulse(9'h180);
        rdc(8'h78, 16'h0080);
        wr(8'h78, 1'b0, 16'h0080);
        rdc(8'h78, 16'h0000);
        converting = 1'b0;
        amask = 16'h0040;
        settle;
        chk({15'h0000, alert_req}, 16'h0000);
        mir = 8'h01;
        amask = 16'h0200;
        settle;
        chk({15'h0000, alert_req}, 16'h0001);
        complete_run;
    end
    initial begin
        #100000;
        mismatches++;
        complete_run;
    end
endmodule
